//--- hdl/mic_pkg.sv
package mic_pkg;

    // ****************************************************
    // Register indices (byte address is four times these)
    // ****************************************************
    localparam logic [6:0] IDX_PIN2_CTL = 7'h55;
    localparam logic [6:0] IDX_PIN1_CTL = 7'h59;
    localparam logic [6:0] IDX_PIN3_CTL = 7'h5a;
    localparam logic [6:0] IDX_PIN0_CTL = 7'h5d;
    localparam logic [6:0] IDX_FLAGS = 7'h60;
    localparam logic [6:0] IDX_PIN_CFG = 7'h61;
    localparam logic [6:0] IDX_STACK = 7'h62;
    localparam logic [6:0] IDX_VBASE = 7'h63;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int CTL_FLAG_BIT = 3;
    localparam int CTL_POL_BIT = 4;
    localparam int CTL_RSV_BIT = 5;
    localparam int FLG_STEP_BIT = 1;
    localparam int FLG_GMASK_BIT = 6;
    localparam int FLG_STACK_BIT = 7;
    localparam int FLG_FLOOR_LSB = 12;

    // ****************************************************
    // Reset values and fixed numbers
    // ****************************************************
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [15:0] STACK_RST = 16'h0000;
    localparam logic [19:0] VBASE_RST = 20'h00000;
    localparam logic [19:0] ACK_ADDR = 20'h00000;
    localparam logic [2:0] LEVEL_MAX = 3'h7;
    localparam logic [5:0] SOFT_KEEP_LO = 6'h20;
    localparam logic [3:0][5:0] PIN_NUM = {6'h1a, 6'h15, 6'h19, 6'h1d};
    localparam logic [3:0][19:0] SPECIAL_VEC =
        {20'h0ffec, 20'h0ffe8, 20'h0fff4, 20'h0fff0};
    localparam logic [3:0] SPECIAL_FLOOR_MAX = 4'h3;

    // ****************************************************
    // Entry sequence step numbers
    // ****************************************************
    localparam int ENTRY_CYCLES = 20;
    localparam logic [4:0] STEP_ACK = 5'h00;
    localparam logic [4:0] STEP_CLR = 5'h01;
    localparam logic [4:0] STEP_PUSH0 = 5'h02;
    localparam logic [4:0] STEP_PUSH3 = 5'h05;
    localparam logic [4:0] STEP_FLOOR = 5'h06;
    localparam logic [4:0] STEP_VEC0 = 5'h07;
    localparam logic [4:0] STEP_VEC3 = 5'h0a;
    localparam logic [4:0] STEP_LAST = 5'(ENTRY_CYCLES - 1);

    // ****************************************************
    // Types
    // ****************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ENTRY = 2'b01,
        ST_LAST = 2'b11
    } mic_state_type;

    typedef enum logic [1:0] {
        SRC_MASK = 2'b00,
        SRC_SPECIAL = 2'b01,
        SRC_SOFT = 2'b10
    } mic_src_type;

    typedef struct packed {
        logic [3:0][2:0] prio;
        logic [3:0] flag;
        logic [3:0] edge_sense;
        logic [3:0] rsv;
        logic [7:0] pin_cfg;
        logic [15:0] flags;
        logic [15:0] sp;
        logic [19:0] vbase;
        logic [3:0] adj_prev;
        logic [3:0] spec_pend;
        mic_state_type state;
        logic [4:0] step;
        mic_src_type kind;
        logic [1:0] sel;
        logic [5:0] num;
        logic [2:0] level;
        logic [15:0] temp;
        logic [19:0] pc;
        logic [19:0] vec;
        logic wait_req;
        logic [31:0] rdata;
        logic mem_rd;
        logic mem_wr;
        logic [19:0] mem_addr;
        logic [7:0] mem_wdata;
        logic busy;
        logic start;
    } mic_regs_type;

    localparam mic_regs_type MIC_REGS_RST = '{
        wait_req: 1'b1,
        state: ST_IDLE,
        kind: SRC_MASK,
        flags: FLAGS_RST,
        sp: STACK_RST,
        vbase: VBASE_RST,
        default: '0
    };

endpackage

//--- hdl/mic_top.sv
// Operation
// - Three-bit level per source, zero disables
// - Source request sets its request flag
// - Acknowledged entry clears the request flag
// - Software may only clear request flag
// - Edge sense selects falling or rising
// - Edge sense rewrite may raise request
// - Global mask flag gates maskable requests
// - Accept needs mask, flag, level above floor
// - Floor n admits levels above n only
// - Decide at instruction end, enter next cycle
// - String instructions suspend for pending request
// - First step reads address zero, clears flag
// - Save flags, clear mask, step, stack (stack kept for soft traps 32 and up)
// - Push flags, push PC, set floor, vector
// - Entry sequence lasts twenty cycles
// - Stack word then PC low, four bytes
// - Some special events raise floor to seven
// - Return restores flags word and floor; the code zeroes flags bits 11:8
// - Highest level wins, fixed tie order
// - Software traps always enter their handler; the code skips a trap that comes in the same cycle as return_in
// - Vector entries are four bytes wide
//
// Implementation choice: the Avalon-MM register port.
module mic_top
    import mic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Avalon-MM register slave
    input wire logic [8:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic avs_waitrequest_out,
    output logic [31:0] avs_readdata_out,
    // Request sources
    input wire logic [3:0] ext_pin_in,
    input wire logic [3:0] special_req_in,
    // CPU sequencer side
    input wire logic instr_done_in,
    input wire logic string_op_in,
    input wire logic soft_trap_in,
    input wire logic [5:0] soft_num_in,
    input wire logic [19:0] pc_in,
    input wire logic return_in,
    input wire logic [15:0] ret_word_in,
    output logic entry_busy_out,
    output logic handler_start_out,
    output logic [15:0] cpu_flags_out,
    // CPU memory cycles of the entry sequence
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [19:0] mem_addr_out,
    output logic [7:0] mem_wdata_out
);

    mic_regs_type st_ff;
    mic_regs_type nxt_st;

    // ****************************************************
    // Next-state logic
    // ****************************************************
    always_comb begin
        logic [3:0] adj;
        logic [3:0] evt;
        logic [3:0] elig;
        logic [2:0] floor;
        logic [2:0] best_lvl;
        logic [1:0] best_idx;
        logic best_any;
        logic [1:0] sp_idx;
        logic [6:0] idx;
        logic [1:0] wr_pin;
        logic wr_is_pin;
        logic [31:0] rd_mux;
        logic [15:0] stk_word;
        logic [4:0] k;

        adj = '0;
        evt = '0;
        elig = '0;
        floor = st_ff.flags[FLG_FLOOR_LSB +: 3];
        best_lvl = '0;
        best_idx = '0;
        best_any = 1'b0;
        sp_idx = '0;
        idx = avs_address_in[8:2];
        wr_pin = '0;
        wr_is_pin = 1'b0;
        rd_mux = '0;
        stk_word = '0;
        k = '0;

        // Everything holds unless changed below
        nxt_st = st_ff;
        nxt_st.mem_rd = 1'b0;
        nxt_st.mem_wr = 1'b0;
        nxt_st.start = 1'b0;

        // Edge detect on sense-adjusted level
        for (int i = 0; i < 4; i++) begin
            adj[i] = st_ff.edge_sense[i] ? ext_pin_in[i] : ~ext_pin_in[i];
            if (st_ff.pin_cfg[2 * i]) begin
                if (st_ff.pin_cfg[2 * i + 1]) begin
                    // Both edges; assumes edge sense left falling
                    evt[i] = adj[i] ^ st_ff.adj_prev[i];
                end else begin
                    // Flipping sense flips adj: spurious edge
                    evt[i] = adj[i] & ~st_ff.adj_prev[i];
                end
            end
        end
        nxt_st.adj_prev = adj;

        // Eligibility and arbitration, lower index wins a tie
        for (int i = 3; i >= 0; i--) begin
            elig[i] = st_ff.flags[FLG_GMASK_BIT]
                & st_ff.flag[i]
                & (st_ff.prio[i] > floor);
            if (elig[i] && st_ff.prio[i] >= best_lvl) begin
                best_lvl = st_ff.prio[i];
                best_idx = 2'(i);
                best_any = 1'b1;
            end
        end

        // Lowest pending special index wins
        for (int i = 3; i >= 0; i--) begin
            if (st_ff.spec_pend[i]) begin
                sp_idx = 2'(i);
            end
        end

        // Read mux, unmapped reads as zero
        case (idx)
            IDX_PIN0_CTL, IDX_PIN1_CTL, IDX_PIN2_CTL, IDX_PIN3_CTL: begin
                wr_is_pin = 1'b1;
            end
            default: begin
                wr_is_pin = 1'b0;
            end
        endcase

        case (idx)
            IDX_PIN1_CTL: wr_pin = 2'h1;
            IDX_PIN2_CTL: wr_pin = 2'h2;
            IDX_PIN3_CTL: wr_pin = 2'h3;
            default: wr_pin = 2'h0;
        endcase
        if (wr_is_pin) begin
            rd_mux = {26'h0, st_ff.rsv[wr_pin], st_ff.edge_sense[wr_pin],
                st_ff.flag[wr_pin], st_ff.prio[wr_pin]};
        end else begin
            case (idx)
                IDX_FLAGS: rd_mux = {16'h0, st_ff.flags};
                IDX_PIN_CFG: rd_mux = {24'h0, st_ff.pin_cfg};
                IDX_STACK: rd_mux = {16'h0, st_ff.sp};
                IDX_VBASE: rd_mux = {12'h0, st_ff.vbase};
                default: rd_mux = '0;
            endcase
        end

        // Bus handshake: one wait cycle, then answer
        nxt_st.wait_req = 1'b1;
        if ((avs_read_in || avs_write_in) && st_ff.wait_req) begin
            nxt_st.wait_req = 1'b0;
            nxt_st.rdata = avs_read_in ? rd_mux : '0;
        end

        // Register writes take effect at the answer edge
        if (avs_write_in && !st_ff.wait_req) begin
            if (wr_is_pin && avs_byteenable_in[0]) begin
                nxt_st.prio[wr_pin] = avs_writedata_in[2:0];
                nxt_st.edge_sense[wr_pin] = avs_writedata_in[CTL_POL_BIT];
                nxt_st.rsv[wr_pin] = avs_writedata_in[CTL_RSV_BIT];
                // Writing one leaves the flag as it is
                if (!avs_writedata_in[CTL_FLAG_BIT]) begin
                    nxt_st.flag[wr_pin] = 1'b0;
                end
            end

            case (idx)
                IDX_FLAGS: begin
                    if (avs_byteenable_in[0]) begin
                        nxt_st.flags[7:0] = avs_writedata_in[7:0];
                    end
                    if (avs_byteenable_in[1]) begin
                        nxt_st.flags[15:8] = avs_writedata_in[15:8];
                    end
                end
                IDX_PIN_CFG: begin
                    if (avs_byteenable_in[0]) begin
                        nxt_st.pin_cfg = avs_writedata_in[7:0];
                    end
                end
                IDX_STACK: begin
                    if (avs_byteenable_in[0]) begin
                        nxt_st.sp[7:0] = avs_writedata_in[7:0];
                    end
                    if (avs_byteenable_in[1]) begin
                        nxt_st.sp[15:8] = avs_writedata_in[15:8];
                    end
                end
                IDX_VBASE: begin
                    if (avs_byteenable_in[0]) begin
                        nxt_st.vbase[7:0] = avs_writedata_in[7:0];
                    end
                    if (avs_byteenable_in[1]) begin
                        nxt_st.vbase[15:8] = avs_writedata_in[15:8];
                    end
                    if (avs_byteenable_in[2]) begin
                        nxt_st.vbase[19:16] = avs_writedata_in[19:16];
                    end
                end
                default: begin
                end
            endcase
        end

        // Sequencer
        unique case (st_ff.state)
            ST_IDLE: begin
                if (return_in) begin
                    // Pop restores level floor too
                    nxt_st.flags = {ret_word_in[11:8], 4'h0,
                        ret_word_in[7:0]};
                    nxt_st.sp = st_ff.sp + 16'h0004;
                end else if (instr_done_in || string_op_in) begin
                    nxt_st.temp = st_ff.flags;
                    nxt_st.pc = pc_in;
                    nxt_st.step = STEP_ACK;
                    if (soft_trap_in && instr_done_in) begin
                        // No mask, floor or arbitration applies
                        nxt_st.kind = SRC_SOFT;
                        nxt_st.num = soft_num_in;
                        nxt_st.vec = st_ff.vbase
                            + {12'h0, soft_num_in, 2'b00};
                        nxt_st.state = ST_ENTRY;
                        nxt_st.busy = 1'b1;
                    end else if (|st_ff.spec_pend) begin
                        // Special events outrank maskable ones
                        nxt_st.kind = SRC_SPECIAL;
                        nxt_st.sel = sp_idx;
                        nxt_st.num = '0;
                        nxt_st.vec = SPECIAL_VEC[sp_idx];
                        nxt_st.state = ST_ENTRY;
                        nxt_st.busy = 1'b1;
                    end else if (best_any) begin
                        nxt_st.kind = SRC_MASK;
                        nxt_st.sel = best_idx;
                        nxt_st.level = best_lvl;
                        nxt_st.num = PIN_NUM[best_idx];
                        nxt_st.vec = st_ff.vbase
                            + {12'h0, PIN_NUM[best_idx], 2'b00};
                        nxt_st.state = ST_ENTRY;
                        nxt_st.busy = 1'b1;
                    end
                end
            end
            ST_ENTRY: begin
                if (st_ff.step == STEP_ACK) begin
                    if (st_ff.kind == SRC_MASK) begin
                        nxt_st.flag[st_ff.sel] = 1'b0;
                    end
                    if (st_ff.kind == SRC_SPECIAL) begin
                        nxt_st.spec_pend[st_ff.sel] = 1'b0;
                    end
                end

                if (st_ff.step == STEP_CLR) begin
                    nxt_st.flags[FLG_GMASK_BIT] = 1'b0;
                    nxt_st.flags[FLG_STEP_BIT] = 1'b0;
                    if (!(st_ff.kind == SRC_SOFT
                        && st_ff.num >= SOFT_KEEP_LO)) begin
                        nxt_st.flags[FLG_STACK_BIT] = 1'b0;
                    end
                end

                if (st_ff.step == STEP_FLOOR) begin
                    if (st_ff.kind == SRC_MASK) begin
                        nxt_st.flags[FLG_FLOOR_LSB +: 3] = st_ff.level;
                    end else if (st_ff.kind == SRC_SPECIAL
                        && st_ff.sel <= SPECIAL_FLOOR_MAX[1:0]
                        && !st_ff.sel[1]) begin
                        nxt_st.flags[FLG_FLOOR_LSB +: 3] = LEVEL_MAX;
                    end
                end

                nxt_st.step = st_ff.step + 5'h01;
                if (nxt_st.step == STEP_LAST) begin
                    nxt_st.state = ST_LAST;
                end
            end
            ST_LAST: begin
                nxt_st.state = ST_IDLE;
                nxt_st.busy = 1'b0;
            end
            default: begin
                nxt_st.state = ST_IDLE;
                nxt_st.busy = 1'b0;
            end
        endcase

        // Memory cycles for the step about to be shown
        stk_word = {st_ff.pc[19:16], st_ff.temp[15:12], st_ff.temp[7:0]};
        if (nxt_st.state != ST_IDLE) begin
            if (nxt_st.step == STEP_ACK) begin
                nxt_st.mem_rd = 1'b1;
                nxt_st.mem_addr = ACK_ADDR;
            end else if (nxt_st.step >= STEP_PUSH0
                && nxt_st.step <= STEP_PUSH3) begin
                // Word first, then PC low, a byte a step
                k = nxt_st.step - STEP_PUSH0;
                nxt_st.mem_wr = 1'b1;
                nxt_st.sp = st_ff.sp - 16'h0001;
                nxt_st.mem_addr = {4'h0, nxt_st.sp};
                case (k[1:0])
                    2'h0: nxt_st.mem_wdata = stk_word[15:8];
                    2'h1: nxt_st.mem_wdata = stk_word[7:0];
                    2'h2: nxt_st.mem_wdata = st_ff.pc[15:8];
                    default: nxt_st.mem_wdata = st_ff.pc[7:0];
                endcase
            end else if (nxt_st.step >= STEP_VEC0
                && nxt_st.step <= STEP_VEC3) begin
                k = nxt_st.step - STEP_VEC0;
                nxt_st.mem_rd = 1'b1;
                nxt_st.mem_addr = nxt_st.vec + {18'h0, k[1:0]};
            end
        end
        nxt_st.start = (nxt_st.state == ST_LAST);

        // Hardware sets win over any clear this cycle
        for (int i = 0; i < 4; i++) begin
            if (evt[i]) begin
                nxt_st.flag[i] = 1'b1;
            end
        end
        nxt_st.spec_pend = nxt_st.spec_pend | special_req_in;
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_ff <= MIC_REGS_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************
    // Outputs straight from the state register
    // ****************************************************
    assign avs_waitrequest_out = st_ff.wait_req;
    assign avs_readdata_out = st_ff.rdata;
    assign entry_busy_out = st_ff.busy;
    assign handler_start_out = st_ff.start;
    assign cpu_flags_out = st_ff.flags;
    assign mem_rd_out = st_ff.mem_rd;
    assign mem_wr_out = st_ff.mem_wr;
    assign mem_addr_out = st_ff.mem_addr;
    assign mem_wdata_out = st_ff.mem_wdata;

endmodule

//--- dv/mic_assertions.sv
module mic_assertions
    import mic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Register bus
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    // Sequencer side
    input wire logic instr_done_in,
    input wire logic soft_trap_in,
    input wire logic return_in,
    input wire logic [15:0] ret_word_in,
    input wire logic entry_busy_out,
    input wire logic handler_start_out,
    input wire logic [15:0] cpu_flags_out,
    // Entry memory cycles
    input wire logic mem_rd_out,
    input wire logic mem_wr_out,
    input wire logic [19:0] mem_addr_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    // ****************************************************
    // Helper logic
    // ****************************************************
    logic [15:0] ret_ff;

    // Popped word of last cycle, for the return check
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ret_ff <= '0;
        end else begin
            ret_ff <= ret_word_in;
        end
    end

    // ****************************************************
    // Properties
    // ****************************************************
    busy_length_a: assert property (
        $rose(entry_busy_out) |-> entry_busy_out [*8] ##12
        handler_start_out ##1 !entry_busy_out)
        else $error("entry length wrong");
    ack_read_a: assert property (
        $rose(entry_busy_out) |-> mem_rd_out && mem_addr_out == ACK_ADDR)
        else $error("no acknowledge read");
    stack_push_a: assert property (
        $rose(entry_busy_out) |-> ##2 mem_wr_out [*4] ##1 !mem_wr_out)
        else $error("stack pushes wrong");
    mask_clear_a: assert property (
        $rose(entry_busy_out) |-> ##2 !cpu_flags_out[FLG_GMASK_BIT])
        else $error("global mask not cleared");
    vector_read_a: assert property (
        $rose(entry_busy_out) |-> ##7 mem_rd_out [*4])
        else $error("vector fetch wrong");
    flag_restore_a: assert property (
        return_in && !entry_busy_out |=>
        cpu_flags_out == {ret_ff[11:8], 4'h0, ret_ff[7:0]})
        else $error("return did not restore flags");
    soft_enter_a: assert property (
        instr_done_in && soft_trap_in && !entry_busy_out |=> entry_busy_out)
        else $error("software trap not entered");
    bus_answer_a: assert property (
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=>
        !avs_waitrequest_out)
        else $error("bus answer late");
endmodule

bind mic_top mic_assertions i_mic_assertions (
    .ref_clk_in, .sys_rst_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .instr_done_in, .soft_trap_in, .return_in,
    .ret_word_in, .entry_busy_out, .handler_start_out, .cpu_flags_out,
    .mem_rd_out, .mem_wr_out, .mem_addr_out
);

//--- dv/mic_cpu_model.sv
module mic_cpu_model
    import mic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Entry memory cycles
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    input wire logic [19:0] mem_addr_in,
    input wire logic [7:0] mem_wdata_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [19:0] addr_q[$];
    logic [7:0] data_q[$];

    // Log each cycle; order matters, so no sorting
    always @(posedge ref_clk_in) begin
        if (!sys_rst_in && (mem_rd_in || mem_wr_in)) begin
            addr_q.push_back(mem_addr_in);
            if (mem_wr_in) begin
                data_q.push_back(mem_wdata_in);
            end
        end
    end
endmodule

//--- dv/test_mic_top.sv
module test_mic_top
    import mic_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_in = 0, sys_rst_in = 1;
    logic [8:0] avs_address_in = '0;
    logic avs_read_in = 0, avs_write_in = 0;
    logic [31:0] avs_writedata_in = '0, avs_readdata_out;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic avs_waitrequest_out, entry_busy_out, handler_start_out;
    logic [3:0] ext_pin_in = '0, special_req_in = '0;
    logic instr_done_in = 0, string_op_in = 0, soft_trap_in = 0;
    logic return_in = 0, mem_rd_out, mem_wr_out;
    logic [5:0] soft_num_in = '0;
    logic [19:0] pc_in = 20'h12345, mem_addr_out;
    logic [15:0] ret_word_in = '0, cpu_flags_out, sp = 16'h0100;
    logic [7:0] mem_wdata_out;
    int errors = 0, n_compared = 0;
    bit hit;

    mic_top i_mic_top (.ref_clk_in, .sys_rst_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in, .avs_waitrequest_out, .avs_readdata_out,
        .ext_pin_in, .special_req_in, .instr_done_in, .string_op_in,
        .soft_trap_in, .soft_num_in, .pc_in, .return_in, .ret_word_in,
        .entry_busy_out, .handler_start_out, .cpu_flags_out,
        .mem_rd_out, .mem_wr_out, .mem_addr_out, .mem_wdata_out);
    mic_cpu_model i_mic_cpu_model (.ref_clk_in, .sys_rst_in,
        .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out),
        .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out));

    // Free running 40 MHz clock
    always #12.5 ref_clk_in = ~ref_clk_in;

    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One Avalon access; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [6:0] idx,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge ref_clk_in);
        avs_address_in <= {idx, 2'b00};
        avs_write_in <= wr;
        avs_read_in <= !wr;
        avs_writedata_in <= d;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        if (n >= 50) begin
            errors++;
            stop_test();
        end
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic wr(input logic [6:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd(input string what, input logic [6:0] idx,
        input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, '0, q);
        check(what, q, exp);
    endtask

    // Decision point, then wait out any entry sequence
    task automatic decide(input logic str, input logic trap);
        int n;
        @(posedge ref_clk_in);
        instr_done_in <= !str;
        string_op_in <= str;
        soft_trap_in <= trap;
        @(posedge ref_clk_in);
        instr_done_in <= 1'b0;
        string_op_in <= 1'b0;
        soft_trap_in <= 1'b0;
        n = 0;
        while (entry_busy_out !== 1'b1 && n < 1) begin
            @(posedge ref_clk_in);
            n++;
        end
        hit = (entry_busy_out === 1'b1);
        n = 0;
        while (entry_busy_out !== 1'b0 && n < 30) begin
            @(posedge ref_clk_in);
            n++;
        end
        if (n >= 30) begin
            errors++;
            stop_test();
        end
    endtask

    // Memory cycles of one entry against the expected stack frame
    task automatic check_log(input logic [19:0] vec, input logic [15:0] w);
        logic [7:0] b [4];
        b = '{w[15:8], w[7:0], pc_in[15:8], pc_in[7:0]};
        check("cycle count", i_mic_cpu_model.addr_q.size(), 9);
        check("ack address", i_mic_cpu_model.addr_q[0], ACK_ADDR);
        for (int i = 0; i < 4; i++) begin
            check("push address", i_mic_cpu_model.addr_q[1 + i], sp - 1 - i);
            check("push data", i_mic_cpu_model.data_q[i], b[i]);
            check("vector address", i_mic_cpu_model.addr_q[5 + i], vec + i);
        end
        sp -= 16'h0004;
        i_mic_cpu_model.addr_q.delete();
        i_mic_cpu_model.data_q.delete();
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        repeat (16) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rd("pin0 reset", IDX_PIN0_CTL, 32'h0);
        rd("flags reset", IDX_FLAGS, 32'h0);
        rd("unmapped", 7'h7f, 32'h0);
        wr(IDX_PIN0_CTL, 32'h25);
        rd("pin0 fields", IDX_PIN0_CTL, 32'h25);
        wr(IDX_PIN0_CTL, 32'h35);
        wr(IDX_PIN1_CTL, 32'h15);
        wr(IDX_PIN_CFG, 32'h05);
        wr(IDX_VBASE, 32'h01000);
        wr(IDX_STACK, 32'h0100);
        $display("test registers done");
        ext_pin_in <= 4'h3;
        rd("pin0 request", IDX_PIN0_CTL, 32'h3d);
        decide(1'b0, 1'b0);
        check("masked entry", hit, 1'b0);
        wr(IDX_FLAGS, 32'h5040);
        decide(1'b0, 1'b0);
        check("floor entry", hit, 1'b0);
        rd("pin0 held", IDX_PIN0_CTL, 32'h3d);
        wr(IDX_FLAGS, 32'h4040);
        decide(1'b0, 1'b0);
        check("pin entry", hit, 1'b1);
        check_log(20'h01074, 16'h1440);
        check("flags entry", cpu_flags_out, 16'h5000);
        rd("pin0 acked", IDX_PIN0_CTL, 32'h35);
        rd("pin1 waiting", IDX_PIN1_CTL, 32'h1d);
        @(posedge ref_clk_in);
        return_in <= 1'b1;
        ret_word_in <= 16'h0440;
        @(posedge ref_clk_in);
        return_in <= 1'b0;
        @(posedge ref_clk_in);
        check("flags return", cpu_flags_out, 16'h4040);
        sp += 16'h0004;
        decide(1'b1, 1'b0);
        check("string entry", hit, 1'b1);
        check_log(20'h01064, 16'h1440);
        $display("test maskable entry done");
        ext_pin_in <= 4'h0;
        wr(IDX_PIN0_CTL, 32'h05);
        rd("edge rewrite", IDX_PIN0_CTL, 32'h0d);
        wr(IDX_PIN_CFG, 32'h07);
        wr(IDX_PIN0_CTL, 32'h05);
        rd("cleared", IDX_PIN0_CTL, 32'h05);
        ext_pin_in <= 4'h1;
        rd("dual edge", IDX_PIN0_CTL, 32'h0d);
        $display("test edge sense done");
        wr(IDX_FLAGS, 32'h7080);
        soft_num_in <= 6'd40;
        decide(1'b0, 1'b1);
        check("soft entry", hit, 1'b1);
        check_log(20'h010a0, 16'h1780);
        check("flags soft", cpu_flags_out, 16'h7080);
        $display("test soft trap done");
        wr(IDX_FLAGS, 32'h0000);
        @(posedge ref_clk_in);
        special_req_in <= 4'h1;
        @(posedge ref_clk_in);
        special_req_in <= 4'h0;
        decide(1'b0, 1'b0);
        check("special entry", hit, 1'b1);
        check_log(20'h0fff0, 16'h1000);
        check("flags special", cpu_flags_out, 16'h7000);
        $display("test special done");
        stop_test();
    end
endmodule
